// [rtl/mm_burst_pkg.sv]
package mm_burst_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 32;
   localparam int BE_W = DATA_W / 8;
   localparam int COUNT_W = 4;
   localparam int MEM_DEPTH = 64;
   localparam int FIFO_DEPTH = 4;
   // zero selects variable latency with the data-valid strobe
   localparam int FIXED_READ_LATENCY = 0;
   localparam bit HOLD_BURST_FIELDS = 1'b0;
   localparam logic [COUNT_W-1:0] COUNT_ONE = 4'h1;
   localparam logic [COUNT_W-1:0] MAX_BURST = 4'h8;

   typedef enum logic [1:0] {
      S_IDLE = 2'b01,
      S_WR = 2'b10
   } slave_state_type;

   typedef enum logic [2:0] {
      M_IDLE = 3'b001,
      M_RD = 3'b010,
      M_WR = 3'b100
   } master_state_type;

   // zero becomes one, anything above the longest burst is cut to it
   function automatic logic [COUNT_W-1:0] legal_count(
      input logic [COUNT_W-1:0] c);
      if (c == 4'h0) begin
         legal_count = COUNT_ONE;
      end else if (c > MAX_BURST) begin
         legal_count = MAX_BURST;
      end else begin
         legal_count = c;
      end
   endfunction
endpackage

// [rtl/mm_burst_if.sv]
`timescale 1ns/1ns
interface mm_burst_if;
   logic [mm_burst_pkg::ADDR_W-1:0] address;
   logic [mm_burst_pkg::COUNT_W-1:0] burstcount;
   logic [mm_burst_pkg::BE_W-1:0] byteenable;
   logic [mm_burst_pkg::DATA_W-1:0] writedata;
   logic [mm_burst_pkg::DATA_W-1:0] readdata;
   logic read;
   logic write;
   logic beginbursttransfer;
   logic waitrequest;
   logic readdatavalid;
   logic writeresponsevalid;

   modport master (
      output address,
      output burstcount,
      output byteenable,
      output writedata,
      output read,
      output write,
      output beginbursttransfer,
      input waitrequest,
      input readdata,
      input readdatavalid,
      input writeresponsevalid
   );

   modport slave (
      input address,
      input burstcount,
      input byteenable,
      input writedata,
      input read,
      input write,
      input beginbursttransfer,
      output waitrequest,
      output readdata,
      output readdatavalid,
      output writeresponsevalid
   );
endinterface

// [rtl/mm_burst_fifo.sv]
`timescale 1ns/1ns
module mm_burst_fifo #(
   parameter int WIDTH = mm_burst_pkg::DATA_W,
   parameter int DEPTH = mm_burst_pkg::FIFO_DEPTH
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL = CW'(DEPTH);
   localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

   logic [WIDTH-1:0] buf_reg [DEPTH];
   logic [PW-1:0] wr_ptr_reg;
   logic [PW-1:0] rd_ptr_reg;
   logic [CW-1:0] count_reg;
   logic push;
   logic pop;

   function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
      next_ptr = (p == LAST) ? '0 : PW'(p + 1'b1);
   endfunction

   assign in_ready = count_reg != FULL;
   assign out_valid = count_reg != '0;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = buf_reg[rd_ptr_reg];

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= next_ptr(wr_ptr_reg);
         end
         if (pop) begin
            rd_ptr_reg <= next_ptr(rd_ptr_reg);
         end
         count_reg <= CW'(count_reg + CW'(push) - CW'(pop));
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < DEPTH; i++) begin
            buf_reg[i] <= '0;
         end
      end else if (push) begin
         buf_reg[wr_ptr_reg] <= in_data;
      end
   end
endmodule

// [rtl/mm_burst_slave.sv]
`timescale 1ns/1ns
module mm_burst_slave #(
   parameter int FIXED_READ_LATENCY = mm_burst_pkg::FIXED_READ_LATENCY,
   parameter int MEM_DEPTH = mm_burst_pkg::MEM_DEPTH,
   parameter int FIFO_DEPTH = mm_burst_pkg::FIFO_DEPTH
) (
   input wire logic clk_sys,
   input wire logic reset,
   mm_burst_if.slave bus,
   input wire logic stall_in,
   input wire logic return_hold,
   output logic busy_out
);
   localparam int ADDR_W = mm_burst_pkg::ADDR_W;
   localparam int DATA_W = mm_burst_pkg::DATA_W;
   localparam int BE_W = mm_burst_pkg::BE_W;
   localparam int COUNT_W = mm_burst_pkg::COUNT_W;
   localparam int IDX_W = $clog2(MEM_DEPTH);
   localparam bit FIXED_MODE = FIXED_READ_LATENCY > 0;
   localparam int LAT_N = FIXED_MODE ? FIXED_READ_LATENCY : 1;

   ////////////////////////////////////////////////////////////////////
   mm_burst_pkg::slave_state_type state_reg;
   logic [ADDR_W-1:0] wr_addr_reg;
   logic [ADDR_W-1:0] rd_addr_reg;
   logic [COUNT_W-1:0] wr_left_reg;
   logic [COUNT_W-1:0] rd_left_reg;
   logic wresp_reg;
   logic [DATA_W-1:0] mem_reg [MEM_DEPTH];
   logic [LAT_N-1:0] lat_valid_reg;
   logic [DATA_W-1:0] lat_data_reg [LAT_N];
   logic wait_int;
   logic idle;
   logic accept_rd;
   logic accept_wr;
   logic wr_last;
   logic rd_busy;
   logic lat_busy;
   logic [COUNT_W-1:0] first_count;
   logic [IDX_W-1:0] wr_index;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [DATA_W-1:0] fifo_out_data;

   function automatic logic [IDX_W-1:0] word_index(
      input logic [ADDR_W-1:0] a);
      word_index = a[IDX_W-1:0];
   endfunction

   function automatic logic [DATA_W-1:0] merge_lanes(
      input logic [DATA_W-1:0] old_word,
      input logic [DATA_W-1:0] new_word,
      input logic [BE_W-1:0] lanes);
      logic [DATA_W-1:0] r;
      r = old_word;
      for (int i = 0; i < BE_W; i++) begin
         if (lanes[i]) begin
            r[8*i +: 8] = new_word[8*i +: 8];
         end
      end
      merge_lanes = r;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // command acceptance and stalling
   assign idle = state_reg == mm_burst_pkg::S_IDLE;
   assign rd_busy = rd_left_reg != '0;
   assign lat_busy = |lat_valid_reg;
   // marker is not needed: the idle state already marks a burst start
   assign first_count = mm_burst_pkg::legal_count(bus.burstcount);

   always_comb begin
      wait_int = stall_in;
      if (idle) begin
         // one read burst generating at a time keeps the pending limit
         if (bus.read && rd_busy) begin
            wait_int = 1'b1;
         end
         // writes wait until every earlier read has been returned
         if (bus.write && (rd_busy || fifo_out_valid || lat_busy)) begin
            wait_int = 1'b1;
         end
      end
   end

   assign bus.waitrequest = wait_int;
   // a dropped read never reaches here and needs no handling
   assign accept_rd = idle && bus.read && !bus.write && !wait_int;
   assign accept_wr = bus.write && !wait_int;
   assign wr_last = idle ? (first_count == mm_burst_pkg::COUNT_ONE)
                         : (wr_left_reg == mm_burst_pkg::COUNT_ONE);

   ////////////////////////////////////////////////////////////////////
   // write burst
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         state_reg <= mm_burst_pkg::S_IDLE;
      end else begin
         case (state_reg)
            mm_burst_pkg::S_IDLE: begin
               if (accept_wr && !wr_last) begin
                  state_reg <= mm_burst_pkg::S_WR;
               end
            end
            mm_burst_pkg::S_WR: begin
               if (accept_wr && wr_last) begin
                  state_reg <= mm_burst_pkg::S_IDLE;
               end
            end
            default: begin
               state_reg <= mm_burst_pkg::S_IDLE;
            end
         endcase
      end
   end

   // later words ignore the address and length on the bus
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         wr_addr_reg <= '0;
         wr_left_reg <= '0;
      end else if (accept_wr) begin
         if (idle) begin
            wr_addr_reg <= ADDR_W'(bus.address + 1'b1);
            wr_left_reg <= COUNT_W'(first_count - 1'b1);
         end else begin
            wr_addr_reg <= ADDR_W'(wr_addr_reg + 1'b1);
            wr_left_reg <= COUNT_W'(wr_left_reg - 1'b1);
         end
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         wresp_reg <= 1'b0;
      end else begin
         wresp_reg <= accept_wr && wr_last;
      end
   end

   assign wr_index = idle ? word_index(bus.address)
                          : word_index(wr_addr_reg);

   // every accepted word is a transfer, even with no lane enabled
   always_ff @(posedge clk_sys) begin
      if (accept_wr) begin
         mem_reg[wr_index] <= merge_lanes(mem_reg[wr_index],
                                          bus.writedata,
                                          bus.byteenable);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // variable latency read burst through the return buffer
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         rd_addr_reg <= '0;
         rd_left_reg <= '0;
      end else if (accept_rd && !FIXED_MODE) begin
         rd_addr_reg <= bus.address;
         rd_left_reg <= first_count;
      end else if (rd_busy && fifo_in_ready) begin
         rd_addr_reg <= ADDR_W'(rd_addr_reg + 1'b1);
         rd_left_reg <= COUNT_W'(rd_left_reg - 1'b1);
      end
   end

   // plain array reads, so extra fetches change nothing
   mm_burst_fifo #(
      .WIDTH(DATA_W),
      .DEPTH(FIFO_DEPTH)
   ) u_return_fifo (
      .clk_sys(clk_sys),
      .reset(reset),
      .in_valid(rd_busy),
      .in_ready(fifo_in_ready),
      .in_data(mem_reg[word_index(rd_addr_reg)]),
      .out_valid(fifo_out_valid),
      .out_ready(!return_hold),
      .out_data(fifo_out_data)
   );

   ////////////////////////////////////////////////////////////////////
   // fixed latency single reads, one per cycle
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         lat_valid_reg <= '0;
      end else begin
         lat_valid_reg[0] <= accept_rd && FIXED_MODE;
         for (int i = 1; i < LAT_N; i++) begin
            lat_valid_reg[i] <= lat_valid_reg[i-1];
         end
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < LAT_N; i++) begin
            lat_data_reg[i] <= '0;
         end
      end else begin
         lat_data_reg[0] <= mem_reg[word_index(bus.address)];
         for (int i = 1; i < LAT_N; i++) begin
            lat_data_reg[i] <= lat_data_reg[i-1];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // answers, in acceptance order
   assign bus.readdata = FIXED_MODE ? lat_data_reg[LAT_N-1]
                                    : fifo_out_data;
   assign bus.readdatavalid = FIXED_MODE ? lat_valid_reg[LAT_N-1]
                              : (fifo_out_valid && !return_hold);
   assign bus.writeresponsevalid = wresp_reg;
   assign busy_out = !idle || rd_busy || fifo_out_valid || lat_busy;
endmodule

// [rtl/mm_burst_master.sv]
`timescale 1ns/1ns
module mm_burst_master #(
   parameter bit HOLD_BURST_FIELDS = mm_burst_pkg::HOLD_BURST_FIELDS
) (
   input wire logic clk_sys,
   input wire logic reset,
   mm_burst_if.master bus,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic cmd_write,
   input wire logic [mm_burst_pkg::ADDR_W-1:0] cmd_address,
   input wire logic [mm_burst_pkg::COUNT_W-1:0] cmd_count,
   input wire logic [mm_burst_pkg::BE_W-1:0] cmd_byteenable,
   input wire logic wr_valid,
   output logic wr_ready,
   input wire logic [mm_burst_pkg::DATA_W-1:0] wr_data,
   input wire logic [mm_burst_pkg::BE_W-1:0] wr_byteenable,
   output logic [mm_burst_pkg::DATA_W-1:0] rd_data,
   output logic rd_valid,
   output logic wr_done
);
   localparam int COUNT_W = mm_burst_pkg::COUNT_W;

   mm_burst_pkg::master_state_type state_reg;
   logic [mm_burst_pkg::ADDR_W-1:0] addr_reg;
   logic [COUNT_W-1:0] count_reg;
   logic [COUNT_W-1:0] load_left_reg;
   logic [COUNT_W-1:0] send_left_reg;
   logic [mm_burst_pkg::BE_W-1:0] be_reg;
   logic [mm_burst_pkg::DATA_W-1:0] wdata_reg;
   logic read_reg;
   logic write_reg;
   logic begin_reg;
   logic first_reg;
   logic [mm_burst_pkg::DATA_W-1:0] rd_data_reg;
   logic rd_valid_reg;
   logic wr_done_reg;
   logic idle;
   logic take_cmd;
   logic bus_take;
   logic load_word;
   logic [COUNT_W-1:0] cmd_len;

   ////////////////////////////////////////////////////////////////////
   assign idle = state_reg == mm_burst_pkg::M_IDLE;
   assign cmd_len = mm_burst_pkg::legal_count(cmd_count);
   // a write command starts only together with its first word
   assign cmd_ready = idle && (!cmd_write || wr_valid);
   assign take_cmd = cmd_valid && cmd_ready;
   assign bus_take = write_reg && !bus.waitrequest;
   assign wr_ready = (idle && cmd_valid && cmd_write) ||
      (state_reg == mm_burst_pkg::M_WR && load_left_reg != '0 &&
       (!write_reg || bus_take));
   assign load_word = wr_valid && wr_ready;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         state_reg <= mm_burst_pkg::M_IDLE;
      end else begin
         case (state_reg)
            mm_burst_pkg::M_IDLE: begin
               if (take_cmd) begin
                  state_reg <= cmd_write ? mm_burst_pkg::M_WR
                                         : mm_burst_pkg::M_RD;
               end
            end
            mm_burst_pkg::M_RD: begin
               if (!bus.waitrequest) begin
                  state_reg <= mm_burst_pkg::M_IDLE;
               end
            end
            mm_burst_pkg::M_WR: begin
               // no other command until the last word is taken
               if (bus_take && send_left_reg == mm_burst_pkg::COUNT_ONE) begin
                  state_reg <= mm_burst_pkg::M_IDLE;
               end
            end
            default: begin
               state_reg <= mm_burst_pkg::M_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // command fields, loaded when a command is taken and held until the slave takes them; the burst marker lasts one cycle only
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         addr_reg <= '0;
         count_reg <= '0;
         read_reg <= 1'b0;
         begin_reg <= 1'b0;
         first_reg <= 1'b0;
      end else begin
         begin_reg <= take_cmd;
         if (take_cmd) begin
            addr_reg <= cmd_address;
            count_reg <= cmd_len;
            read_reg <= !cmd_write;
            first_reg <= 1'b1;
         end else begin
            if (state_reg == mm_burst_pkg::M_RD && !bus.waitrequest) begin
               read_reg <= 1'b0;
               first_reg <= 1'b0;
            end
            if (bus_take) begin
               first_reg <= 1'b0;
            end
         end
      end
   end

   // write word register; write drops while no word is ready
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         write_reg <= 1'b0;
         wdata_reg <= '0;
         be_reg <= '0;
         load_left_reg <= '0;
         send_left_reg <= '0;
      end else begin
         if (take_cmd && !cmd_write) begin
            be_reg <= (cmd_len == mm_burst_pkg::COUNT_ONE) ?
                      cmd_byteenable : '1;
         end
         if (load_word) begin
            wdata_reg <= wr_data;
            be_reg <= wr_byteenable;
            write_reg <= 1'b1;
         end else if (bus_take) begin
            write_reg <= 1'b0;
         end
         if (take_cmd && cmd_write) begin
            load_left_reg <= COUNT_W'(cmd_len - 1'b1);
            send_left_reg <= cmd_len;
         end else begin
            if (load_word) begin
               load_left_reg <= COUNT_W'(load_left_reg - 1'b1);
            end
            if (bus_take) begin
               send_left_reg <= COUNT_W'(send_left_reg - 1'b1);
            end
         end
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         rd_data_reg <= '0;
         rd_valid_reg <= 1'b0;
         wr_done_reg <= 1'b0;
      end else begin
         rd_valid_reg <= bus.readdatavalid;
         wr_done_reg <= bus.writeresponsevalid;
         if (bus.readdatavalid) begin
            rd_data_reg <= bus.readdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   assign bus.address = (HOLD_BURST_FIELDS || first_reg) ? addr_reg : '0;
   assign bus.burstcount = (HOLD_BURST_FIELDS || first_reg) ?
                           count_reg : '0;
   assign bus.byteenable = be_reg;
   assign bus.writedata = wdata_reg;
   assign bus.read = read_reg;
   assign bus.write = write_reg;
   assign bus.beginbursttransfer = begin_reg;
   assign rd_data = rd_data_reg;
   assign rd_valid = rd_valid_reg;
   assign wr_done = wr_done_reg;
endmodule

// [test/mm_burst_port_asserts.sv]
`timescale 1ns/1ns
module mm_burst_port_asserts (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [15:0] address,
   input wire logic [3:0] burstcount,
   input wire logic [3:0] byteenable,
   input wire logic [31:0] writedata,
   input wire logic read,
   input wire logic write,
   input wire logic beginbursttransfer,
   input wire logic waitrequest,
   input wire logic readdatavalid,
   input wire logic writeresponsevalid
);
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (reset);
   logic [3:0] left_reg, len;
   logic [5:0] pend_reg;
   logic wt, rt;
   assign wt = write && !waitrequest;
   assign rt = read && !write && !waitrequest;
   assign len = burstcount == 4'h0 ? 4'h1 :
      (burstcount > 4'h8 ? 4'h8 : burstcount);
   ////////////////////////////////////////////////////////////////////////
   // words still owed in the open write burst
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         left_reg <= 4'h0;
      end else if (wt) begin
         left_reg <= (left_reg == 4'h0 ? len : left_reg) - 4'h1;
      end
   end
   // read words taken but not yet returned
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         pend_reg <= 6'h00;
      end else begin
         pend_reg <= pend_reg + (rt ? {2'h0, len} : 6'h00)
            - {5'h00, readdatavalid};
      end
   end
   ////////////////////////////////////////////////////////////////////////
   sequence s_last_word;
      wt && (left_reg == 4'h1 || (left_reg == 4'h0 && len == 4'h1));
   endsequence
   sequence s_wr_stalled;
      write && waitrequest;
   endsequence
   a_resp_after_last: assert property (
      s_last_word |=> writeresponsevalid) else $error("response missing");
   a_resp_has_cause: assert property (
      writeresponsevalid |-> $past(wt) && left_reg == 4'h0)
      else $error("stray write response");
   a_marker_one_cycle: assert property (
      beginbursttransfer |=> !beginbursttransfer) else $error("long marker");
   a_marker_first: assert property (
      beginbursttransfer |-> (read || write) && left_reg == 4'h0)
      else $error("marker not at burst start");
   a_wr_fields_held: assert property (
      s_wr_stalled |=> write && $stable(writedata) && $stable(byteenable)
      && $stable(burstcount) && $stable(address)) else $error("write moved");
   a_rd_cmd_held: assert property (
      read && waitrequest |=> read && $stable(address)
      && $stable(burstcount)) else $error("read moved");
   a_data_has_cmd: assert property (
      readdatavalid |-> pend_reg != 6'h00) else $error("orphan read data");
   a_wr_waits_reads: assert property (
      write && pend_reg != 6'h00 |-> waitrequest) else $error("write passed");
   a_read_locked_out: assert property (
      rt |-> left_reg == 4'h0) else $error("read inside write burst");
   a_reset_quiet: assert property (
      $fell(reset) |-> !readdatavalid && !writeresponsevalid)
      else $error("strobe after reset");
endmodule

// [test/mm_slave_pipelined_burst_port_test.sv]
`timescale 1ns/1ns
module mm_slave_pipelined_burst_port_test;
   logic clk_sys, reset, stall_in, return_hold;
   logic cmd_valid, cmd_write, wr_valid;
   logic cmd_ready, wr_ready, rd_valid, wr_done, busy_out;
   logic [15:0] cmd_address;
   logic [3:0] cmd_count, cmd_byteenable, wr_byteenable;
   logic [31:0] wr_data, rd_data;
   logic [31:0] ref_mem [64];
   int n_mismatch, num_checks, cycles;
   mm_burst_if mm_burst_if_i ();
   mm_burst_slave mm_burst_slave_i (.clk_sys(clk_sys), .reset(reset),
      .bus(mm_burst_if_i), .stall_in(stall_in),
      .return_hold(return_hold), .busy_out(busy_out));
   mm_burst_master mm_burst_master_i (.clk_sys(clk_sys), .reset(reset),
      .bus(mm_burst_if_i), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
      .cmd_write(cmd_write), .cmd_address(cmd_address),
      .cmd_count(cmd_count), .cmd_byteenable(cmd_byteenable),
      .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
      .wr_byteenable(wr_byteenable), .rd_data(rd_data),
      .rd_valid(rd_valid), .wr_done(wr_done));
   mm_burst_port_asserts mm_burst_port_asserts_i (.clk_sys(clk_sys),
      .reset(reset), .address(mm_burst_if_i.address),
      .burstcount(mm_burst_if_i.burstcount),
      .byteenable(mm_burst_if_i.byteenable),
      .writedata(mm_burst_if_i.writedata), .read(mm_burst_if_i.read),
      .write(mm_burst_if_i.write),
      .beginbursttransfer(mm_burst_if_i.beginbursttransfer),
      .waitrequest(mm_burst_if_i.waitrequest),
      .readdatavalid(mm_burst_if_i.readdatavalid),
      .writeresponsevalid(mm_burst_if_i.writeresponsevalid));
   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 4000) begin
         n_mismatch++;
         close_out();
      end
   end
   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic check_word(input logic [31:0] got, exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic check_flag(input logic got, exp);
      check_word({31'h0, got}, {31'h0, exp});
   endtask
   ////////////////////////////////////////////////////////////////////////
   // odd words take the given lanes, even words all lanes
   task automatic wr_burst(input logic [15:0] a, input int n,
      input logic [3:0] be, input int gap);
      logic [31:0] d;
      logic [3:0] wb;
      int t;
      for (int k = 0; k < n; k++) begin
         d = {a, 8'h3c, 8'(k)};
         wb = k[0] ? be : 4'hf;
         @(posedge clk_sys);
         if (k == 2 && gap > 0) begin
            wr_valid <= 1'b0;
            repeat (gap) @(posedge clk_sys);
         end
         cmd_valid <= k == 0;
         cmd_write <= 1'b1;
         cmd_address <= a;
         cmd_count <= 4'(n);
         wr_valid <= 1'b1;
         wr_data <= d;
         wr_byteenable <= wb;
         t = 0;
         do begin
            @(negedge clk_sys);
            t++;
         end while ((k == 0 ? cmd_ready : wr_ready) !== 1'b1 && t < 50);
         for (int b = 0; b < 4; b++) begin
            if (wb[b]) ref_mem[6'(a + 16'(k))][8*b +: 8] = d[8*b +: 8];
         end
      end
      @(posedge clk_sys);
      cmd_valid <= 1'b0;
      wr_valid <= 1'b0;
      t = 0;
      do begin
         @(negedge clk_sys);
         t++;
      end while (wr_done !== 1'b1 && t < 60);
      check_flag(wr_done, 1'b1);
   endtask
   // one or two read commands, words checked in order of acceptance
   task automatic rd_burst(input logic [15:0] a1, input int n1,
      input logic [15:0] a2, input int n2, input int hold);
      int got, sent, cyc;
      got = 0;
      sent = 0;
      cyc = 0;
      @(posedge clk_sys);
      cmd_valid <= 1'b1;
      cmd_write <= 1'b0;
      cmd_address <= a1;
      cmd_count <= 4'(n1);
      cmd_byteenable <= 4'hf;
      return_hold <= hold > 0;
      while (got < n1 + n2 && cyc < 200) begin
         @(negedge clk_sys);
         if (rd_valid === 1'b1) begin
            check_word(rd_data, ref_mem[got < n1 ? 6'(a1 + 16'(got)) :
               6'(a2 + 16'(got - n1))]);
            got++;
         end
         if (cmd_valid && !cmd_write && cmd_ready === 1'b1) sent++;
         @(posedge clk_sys);
         cyc++;
         if (sent == 1 && n2 > 0) begin
            cmd_address <= a2;
            cmd_count <= 4'(n2);
         end
         if (cmd_valid && !cmd_write && sent == (n2 > 0 ? 2 : 1)) begin
            cmd_valid <= 1'b0;
         end
         if (hold > 0 && cyc == hold) begin
            check_flag(got == 0, 1'b1);
            return_hold <= 1'b0;
         end
      end
      check_flag(got == n1 + n2, 1'b1);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_fill();
      wr_burst(16'h0000, 8, 4'hf, 0);
      wr_burst(16'h0008, 8, 4'hf, 0);
      rd_burst(16'h0000, 8, 16'h0008, 8, 0);
      $display("fill test done");
   endtask
   task automatic t_lanes();
      wr_burst(16'h0002, 4, 4'h0, 2);
      wr_burst(16'h0003, 3, 4'h5, 0);
      rd_burst(16'h0000, 8, 16'h0000, 0, 0);
      $display("lanes test done");
   endtask
   task automatic t_stall();
      fork
         wr_burst(16'h0020, 5, 4'hf, 0);
         begin
            repeat (3) @(posedge clk_sys);
            stall_in <= 1'b1;
            repeat (3) @(posedge clk_sys);
            stall_in <= 1'b0;
         end
      join
      rd_burst(16'h0020, 5, 16'h0000, 0, 0);
      $display("stall test done");
   endtask
   task automatic t_order();
      fork
         rd_burst(16'h0008, 8, 16'h0000, 0, 10);
         begin
            repeat (3) @(posedge clk_sys);
            wr_burst(16'h0030, 1, 4'hf, 0);
         end
      join
      rd_burst(16'h0030, 1, 16'h0000, 0, 0);
      $display("order test done");
   endtask
   task automatic t_reset_mid();
      @(posedge clk_sys);
      return_hold <= 1'b1;
      cmd_valid <= 1'b1;
      cmd_write <= 1'b0;
      cmd_address <= 16'h0000;
      cmd_count <= 4'h4;
      @(posedge clk_sys);
      cmd_valid <= 1'b0;
      repeat (4) @(posedge clk_sys);
      @(negedge clk_sys);
      check_flag(busy_out, 1'b1);
      check_flag(mm_burst_if_i.readdatavalid, 1'b0);
      @(posedge clk_sys);
      reset <= 1'b1;
      @(negedge clk_sys);
      check_flag(busy_out, 1'b0);
      check_flag(mm_burst_if_i.readdatavalid, 1'b0);
      @(posedge clk_sys);
      reset <= 1'b0;
      return_hold <= 1'b0;
      repeat (6) begin
         @(negedge clk_sys);
         check_flag(rd_valid, 1'b0);
      end
      rd_burst(16'h0000, 2, 16'h0000, 0, 0);
      $display("reset test done");
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      reset = 1'b1;
      stall_in = 1'b0;
      return_hold = 1'b0;
      cmd_valid = 1'b0;
      cmd_write = 1'b0;
      wr_valid = 1'b0;
      cmd_address = 16'h0000;
      cmd_count = 4'h1;
      cmd_byteenable = 4'hf;
      wr_byteenable = 4'hf;
      wr_data = 32'h0000_0000;
      n_mismatch = 0;
      num_checks = 0;
      cycles = 0;
      repeat (10) @(posedge clk_sys);
      reset <= 1'b0;
      t_fill();
      t_lanes();
      t_stall();
      t_order();
      t_reset_mid();
      close_out();
   end
endmodule
